// ---- hw/cpl_defs.svh ----
// constants shared by both ends of the crosspoint program loader
`ifndef CPL_DEFS_SVH
`define CPL_DEFS_SVH
`define CPL_WORD_W      80
`define CPL_PAD_W       40
`define CPL_MAP_W       40
`define CPL_NUM_OUT     8
`define CPL_NUM_IN      16
`define CPL_SRC_W       4
`define CPL_ENT_W       5
`define CPL_ADDR_W      3
`define CPL_POS_W       7
`define CPL_OFF         1'b0
`define CPL_CLK_NS      4
`define CPL_HALF_NS     16
`define CPL_HALF_CYC    ((`CPL_HALF_NS + `CPL_CLK_NS - 1) / `CPL_CLK_NS)
`endif

// ---- hw/cpl_pkg.sv ----
// types and entry packing shared by both ends
`include "cpl_defs.svh"
package cpl_pkg;
  typedef logic [`CPL_NUM_OUT*`CPL_SRC_W-1:0] cpl_srcs_t;
  typedef logic [`CPL_NUM_OUT-1:0]            cpl_ons_t;
  typedef logic [`CPL_ENT_W-1:0]              cpl_ent_t;
  typedef logic [`CPL_MAP_W-1:0]              cpl_map_t;
  typedef enum logic [3:0] {
    CPL_H_IDLE = 4'b0001,
    CPL_H_HIGH = 4'b0010,
    CPL_H_LOW  = 4'b0100,
    CPL_H_UPD  = 4'b1000
  } cpl_hstate_e;

  // source bit 0 travels first, the enable bit last
  function automatic cpl_ent_t pack_entry(input logic [`CPL_SRC_W-1:0] src,
                                          input logic                  on);
    return {src[0], src[1], src[2], src[3], on};
  endfunction

  function automatic cpl_map_t build_map(input cpl_srcs_t s,
                                         input cpl_ons_t  o);
    cpl_map_t m;
    m = '0;
    for (int k = 0; k < `CPL_NUM_OUT; k++)
      m[k*`CPL_ENT_W +: `CPL_ENT_W] =
        pack_entry(s[k*`CPL_SRC_W +: `CPL_SRC_W], o[k]);
    return m;
  endfunction

  function automatic cpl_srcs_t map_srcs(input cpl_map_t m);
    cpl_srcs_t s;
    cpl_ent_t  e;
    s = '0;
    for (int k = 0; k < `CPL_NUM_OUT; k++)
    begin
      e = m[k*`CPL_ENT_W +: `CPL_ENT_W];
      s[k*`CPL_SRC_W +: `CPL_SRC_W] = {e[1], e[2], e[3], e[4]};
    end
    return s;
  endfunction

  function automatic cpl_ons_t map_ons(input cpl_map_t m);
    cpl_ons_t o;
    o = '0;
    for (int k = 0; k < `CPL_NUM_OUT; k++)
      o[k] = m[k*`CPL_ENT_W];
    return o;
  endfunction
endpackage

// ---- hw/cpl_prog_if.sv ----
// programming pins between host controller and crosspoint device
`timescale 1ns/10ps
`default_nettype none
`include "cpl_defs.svh"
interface cpl_prog_if;
  logic                   ce_n;
  logic                   prog_clk;
  logic                   data_in;
  logic                   data_out;
  logic                   update_n;
  logic                   load_mode_select;
  logic [`CPL_ADDR_W-1:0] output_select_lines;
  logic [`CPL_SRC_W-1:0]  source_select_bits;
  logic                   output_on_bit;
  logic                   reset_n;
  modport dev (
    input  ce_n, prog_clk, data_in, update_n, load_mode_select,
    input  output_select_lines, source_select_bits, output_on_bit, reset_n,
    output data_out
  );
  modport host (
    output ce_n, prog_clk, data_in, update_n, load_mode_select,
    output output_select_lines, source_select_bits, output_on_bit, reset_n,
    input  data_out
  );
endinterface
`default_nettype wire

// ---- hw/cpl_device.sv ----
// crosspoint program loader, device end: load rank and update latches
`timescale 1ns/10ps
`default_nettype none
`include "cpl_defs.svh"
// Summary of operation
// - serial pass is 80 bits, 40 zeros first
// - mode select low means serial loading
// - clocked data accepted only with enable low
// - update held high while shifting, else flow-through
// - serial bit sampled on each falling clock
// - per output four source bits and enable
// - highest output entry shifted first, descending
// - latches transparent while update and enable low
// - daisy chain, last device data sent first
// - parallel mode changes one entry only
// - reset disables outputs, keeps register contents
// - program all outputs before partial updates
// - no enable plus update low before loading
// - parallel setup: mode, update high, clock high
// - parallel falling clock captures, update applies
// - several parallel writes, then one update
module cpl_device (
  // system
  input  wire logic                        CLK_SYS,
  input  wire logic                        SRST,
  // programming pins
  cpl_prog_if.dev                          PINS,
  // matrix control
  output var  cpl_pkg::cpl_srcs_t          ROUTE_SRC,
  output var  cpl_pkg::cpl_ons_t           ROUTE_ON,
  output var  logic [`CPL_NUM_OUT*`CPL_NUM_IN-1:0] ROUTE_XPT
);
  import cpl_pkg::*;

  localparam int XPT_W = `CPL_NUM_OUT * `CPL_NUM_IN;
  localparam cpl_ons_t ALL_OFF = {`CPL_NUM_OUT{`CPL_OFF}};

  // load rank and pin clock history
  logic [`CPL_WORD_W-1:0] shift_ff;
  logic [`CPL_WORD_W-1:0] nxt_shift;
  logic                   clk_prev_ff;
  // update latches and decoded matrix
  cpl_srcs_t              src_ff;
  cpl_srcs_t              nxt_src;
  cpl_ons_t               on_ff;
  cpl_ons_t               nxt_on;
  logic [XPT_W-1:0]       xpt_ff;
  logic [XPT_W-1:0]       nxt_xpt;

  // write one entry of the map, leaving every other bit alone
  function automatic logic [`CPL_WORD_W-1:0] put_entry(
    input logic [`CPL_WORD_W-1:0] w,
    input logic [`CPL_ADDR_W-1:0] addr,
    input cpl_ent_t               e
  );
    logic [`CPL_WORD_W-1:0] r;
    r = w;
    for (int k = 0; k < `CPL_NUM_OUT; k++)
    begin
      if (addr == k[`CPL_ADDR_W-1:0])
      begin
        r[k*`CPL_ENT_W +: `CPL_ENT_W] = e;
      end
    end
    return r;
  endfunction

  // one stage per output row at most; none while the output is off
  function automatic logic [`CPL_NUM_IN-1:0] row_decode(
    input logic [`CPL_SRC_W-1:0] src,
    input logic                  on
  );
    logic [`CPL_NUM_IN-1:0] r;
    r = '0;
    if (on)
    begin
      r[src] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [XPT_W-1:0] decode_xpt(input cpl_srcs_t s,
                                                  input cpl_ons_t  o);
    logic [XPT_W-1:0] x;
    x = '0;
    for (int k = 0; k < `CPL_NUM_OUT; k++)
    begin
      x[k*`CPL_NUM_IN +: `CPL_NUM_IN] =
        row_decode(s[k*`CPL_SRC_W +: `CPL_SRC_W], o[k]);
    end
    return x;
  endfunction

  wire                    clk_fall;
  wire                    shift_en;
  wire                    par_mode;
  wire                    ser_take;
  wire                    par_take;
  wire                    latch_open;
  wire                    off_force;
  cpl_ent_t               par_entry;
  logic [`CPL_WORD_W-1:0] ser_word;
  logic [`CPL_WORD_W-1:0] par_word;
  cpl_map_t               load_map;
  cpl_srcs_t              rank_src;
  cpl_ons_t               rank_on;
  cpl_ons_t               latched_on;

  // the pin clock is sampled like any other input; one tick of lag
  assign clk_fall   = clk_prev_ff & ~PINS.prog_clk;
  assign shift_en   = clk_fall & ~PINS.ce_n;
  assign par_mode   = PINS.load_mode_select;
  assign ser_take   = shift_en & ~par_mode;
  assign par_take   = shift_en & par_mode;
  // level latches become a one-cycle flow-through on the system clock
  assign latch_open = ~PINS.ce_n & ~PINS.update_n;
  assign off_force  = ~PINS.reset_n;

  assign par_entry = pack_entry(PINS.source_select_bits,
                                PINS.output_on_bit);
  // new bit enters at the bottom, upper 40 positions hold the padding
  assign ser_word  = {shift_ff[`CPL_WORD_W-2:0], PINS.data_in};
  assign par_word  = put_entry(shift_ff, PINS.output_select_lines,
                               par_entry);
  assign nxt_shift  = ser_take ? ser_word :
                      par_take ? par_word : shift_ff;
  assign load_map   = nxt_shift[`CPL_MAP_W-1:0];
  assign rank_src   = map_srcs(load_map);
  assign rank_on    = map_ons(load_map);

  // flow-through so the matrix follows the load rank while open
  assign nxt_src    = latch_open ? rank_src : src_ff;
  assign latched_on = latch_open ? rank_on : on_ff;
  // reset only touches the enables, never the load rank
  assign nxt_on     = off_force ? ALL_OFF : latched_on;
  assign nxt_xpt   = decode_xpt(nxt_src, nxt_on);

  // far end of the rank feeds the next device in a chain
  assign PINS.data_out = shift_ff[`CPL_WORD_W-1];

  assign ROUTE_SRC = src_ff;
  assign ROUTE_ON  = on_ff;
  assign ROUTE_XPT = xpt_ff;

  // history idles high like the pin, so leaving reset makes no false fall
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      clk_prev_ff <= 1'b1;
    end
    else
    begin
      clk_prev_ff <= PINS.prog_clk;
    end
  end

  // a defined start for the rank; the pin reset never clears it
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      shift_ff <= '0;
    end
    else
    begin
      shift_ff <= nxt_shift;
    end
  end

  // matrix control starts with every output off
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      src_ff <= '0;
    end
    else
    begin
      src_ff <= nxt_src;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      on_ff <= '0;
    end
    else
    begin
      on_ff <= nxt_on;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      xpt_ff <= '0;
    end
    else
    begin
      xpt_ff <= nxt_xpt;
    end
  end
endmodule
`default_nettype wire

// ---- hw/cpl_host.sv ----
// crosspoint program loader, host end: drives the programming pins
`timescale 1ns/10ps
`default_nettype none
`include "cpl_defs.svh"
module cpl_host #(
  parameter int CHAIN_LEN = 1,
  parameter int HALF_CYC  = `CPL_HALF_CYC,
  parameter int CNT_W     = 8
) (
  // system
  input  wire logic                        CLK_SYS,
  input  wire logic                        SRST,
  // programming pins
  cpl_prog_if.host                         PINS,
  // command
  input  wire logic                        CMD_VALID,
  output logic                             CMD_READY,
  input  wire logic                        CMD_SERIAL,
  input  wire logic                        CMD_COMMIT,
  input  wire logic [`CPL_ADDR_W-1:0]      CMD_ADDR,
  input  wire logic [`CPL_SRC_W-1:0]       CMD_SRC,
  input  wire logic                        CMD_ON,
  input  wire cpl_pkg::cpl_srcs_t [CHAIN_LEN-1:0] MAP_SRC,
  input  wire cpl_pkg::cpl_ons_t  [CHAIN_LEN-1:0] MAP_ON,
  output logic                             CMD_DONE,
  // output disable request
  input  wire logic                        RESET_REQ
);
  import cpl_pkg::*;

  localparam int DEV_W = (CHAIN_LEN > 1) ? $clog2(CHAIN_LEN) : 1;
  localparam logic [DEV_W-1:0]      DEV_LAST = DEV_W'(CHAIN_LEN - 1);
  localparam logic [CNT_W-1:0]      TICK_AT  = CNT_W'(HALF_CYC - 1);
  localparam logic [`CPL_POS_W-1:0] POS_LAST = `CPL_POS_W'(`CPL_WORD_W - 1);
  localparam logic [`CPL_POS_W-1:0] POS_PAD  = `CPL_POS_W'(`CPL_PAD_W);

  cpl_hstate_e            state_ff;
  logic [CNT_W-1:0]       div_ff;
  logic [`CPL_POS_W-1:0]  pos_ff;
  logic [DEV_W-1:0]       dev_ff;
  logic                   ser_ff;
  logic                   commit_ff;
  logic                   ce_n_ff;
  logic                   clk_ff;
  logic                   din_ff;
  logic                   upd_n_ff;
  logic                   mode_ff;
  logic [`CPL_ADDR_W-1:0] addr_ff;
  logic [`CPL_SRC_W-1:0]  src_ff;
  logic                   on_ff;
  logic                   rst_n_ff;
  logic                   done_ff;

  // padding first, then entries from the highest output down
  function automatic logic bit_of(input logic [`CPL_POS_W-1:0] pos,
                                  input cpl_map_t              m);
    logic [`CPL_POS_W-1:0] idx;
    idx = POS_LAST - pos;
    return (pos < POS_PAD) ? 1'b0 : m[idx[5:0]];
  endfunction

  wire                  tick     = (div_ff == TICK_AT);
  wire                  last_pos = (pos_ff == POS_LAST);
  wire                  last_bit = ser_ff & last_pos & (dev_ff == '0);
  wire [`CPL_POS_W-1:0] nxt_pos  = last_pos ? '0 : pos_ff + 1'b1;
  wire [DEV_W-1:0]      nxt_dev  = last_pos ? dev_ff - 1'b1 : dev_ff;
  cpl_map_t             nxt_map;
  wire                  nxt_bit;
  wire                  idle     = (state_ff == CPL_H_IDLE);
  wire                  start    = idle & CMD_VALID;

  // the last device of the chain is served first
  assign nxt_map   = build_map(MAP_SRC[nxt_dev], MAP_ON[nxt_dev]);
  assign nxt_bit   = bit_of(nxt_pos, nxt_map);
  assign CMD_READY = idle;
  assign CMD_DONE  = done_ff;

  assign PINS.ce_n                = ce_n_ff;
  assign PINS.prog_clk            = clk_ff;
  assign PINS.data_in             = din_ff;
  assign PINS.update_n            = upd_n_ff;
  assign PINS.load_mode_select    = mode_ff;
  assign PINS.output_select_lines = addr_ff;
  assign PINS.source_select_bits  = src_ff;
  assign PINS.output_on_bit       = on_ff;
  assign PINS.reset_n             = rst_n_ff;

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || idle || tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      state_ff  <= CPL_H_IDLE;
      ce_n_ff   <= 1'b1;
      clk_ff    <= 1'b1;
      upd_n_ff  <= 1'b1;
      mode_ff   <= 1'b1;
      din_ff    <= 1'b0;
      addr_ff   <= '0;
      src_ff    <= '0;
      on_ff     <= 1'b0;
      pos_ff    <= '0;
      dev_ff    <= '0;
      ser_ff    <= 1'b0;
      commit_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
      done_ff   <= 1'b0;
    end
    else
    begin
      rst_n_ff <= ~RESET_REQ;
      done_ff  <= 1'b0;
      case (state_ff)
        CPL_H_IDLE:
          if (start)
          begin
            // update stays high so nothing reaches the matrix yet
            mode_ff   <= ~CMD_SERIAL;
            ce_n_ff   <= 1'b0;
            upd_n_ff  <= 1'b1;
            clk_ff    <= 1'b1;
            din_ff    <= 1'b0;
            addr_ff   <= CMD_ADDR;
            src_ff    <= CMD_SRC;
            on_ff     <= CMD_ON;
            pos_ff    <= '0;
            dev_ff    <= DEV_LAST;
            ser_ff    <= CMD_SERIAL;
            commit_ff <= CMD_COMMIT;
            state_ff  <= CPL_H_HIGH;
          end
        CPL_H_HIGH:
          if (tick)
          begin
            clk_ff   <= 1'b0;
            state_ff <= CPL_H_LOW;
          end
        CPL_H_LOW:
          if (tick)
          begin
            clk_ff <= 1'b1;
            if (ser_ff && !last_bit)
            begin
              pos_ff   <= nxt_pos;
              dev_ff   <= nxt_dev;
              din_ff   <= nxt_bit;
              state_ff <= CPL_H_HIGH;
            end
            else if (ser_ff || commit_ff)
            begin
              upd_n_ff <= 1'b0;
              state_ff <= CPL_H_UPD;
            end
            else
            begin
              ce_n_ff  <= 1'b1;
              done_ff  <= 1'b1;
              state_ff <= CPL_H_IDLE;
            end
          end
        CPL_H_UPD:
          if (tick)
          begin
            upd_n_ff <= 1'b1;
            ce_n_ff  <= 1'b1;
            done_ff  <= 1'b1;
            state_ff <= CPL_H_IDLE;
          end
        default:
          state_ff <= CPL_H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- testbench/cpl_monitor.sv ----
// concurrent checks on the programming pins and the matrix control
`timescale 1ns/10ps
`default_nettype none
`include "cpl_defs.svh"
module cpl_monitor (
  // system
  input wire logic               CLK_SYS,
  input wire logic               SRST,
  // programming pins
  input wire logic               ce_n,
  input wire logic               prog_clk,
  input wire logic               data_in,
  input wire logic               data_out,
  input wire logic               update_n,
  input wire logic               load_mode_select,
  input wire logic [2:0]         output_select_lines,
  input wire logic [3:0]         source_select_bits,
  input wire logic               output_on_bit,
  input wire logic               reset_n,
  // matrix control
  input wire cpl_pkg::cpl_srcs_t ROUTE_SRC,
  input wire cpl_pkg::cpl_ons_t  ROUTE_ON,
  input wire logic [127:0]       ROUTE_XPT
);
  import cpl_pkg::*;
  // copy of the load rank, rebuilt from the pins alone
  logic [79:0]  mirror_ff;
  logic [6:0]   pos_ff;
  logic         clk_q_ff;
  cpl_srcs_t    exp_src;
  cpl_ons_t     exp_on;
  logic [127:0] exp_xpt;
  wire logic       take = clk_q_ff & ~prog_clk & ~ce_n;
  wire logic       t_ser = take & ~load_mode_select;
  wire logic       t_par = take & load_mode_select;
  wire logic [6:0] a_pos = 7'(output_select_lines) * 7'h05;
  wire logic [4:0] ent = {source_select_bits[0], source_select_bits[1],
                          source_select_bits[2], source_select_bits[3],
                          output_on_bit};

  always_ff @(posedge CLK_SYS)
    if (SRST)
      mirror_ff <= '0;
    else if (t_ser)
      mirror_ff <= {mirror_ff[78:0], data_in};
    else if (t_par)
      mirror_ff[a_pos +: 5] <= ent;

  // position restarts whenever the device is deselected
  always_ff @(posedge CLK_SYS)
    pos_ff <= (SRST | ce_n) ? 7'h00 : pos_ff + 7'(t_ser);

  always_ff @(posedge CLK_SYS)
    clk_q_ff <= SRST ? 1'b1 : prog_clk;

  for (genvar k = 0; k < 8; k++)
  begin : g_dec
    assign exp_on[k] = mirror_ff[5*k];
    for (genvar j = 0; j < 4; j++)
    begin : g_bit
      assign exp_src[4*k+j] = mirror_ff[5*k+4-j];
    end
    assign exp_xpt[16*k +: 16] =
      ROUTE_ON[k] ? (16'h0001 << ROUTE_SRC[4*k +: 4]) : 16'h0000;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  a_dout_far_end:
    assert property (data_out == mirror_ff[79])
    else $error("serial output is not the far register bit");
  a_src_copy:
    assert property (!ce_n && !update_n |=> ROUTE_SRC == exp_src)
    else $error("open latch did not pass source fields");
  a_on_copy:
    assert property (!ce_n && !update_n && reset_n |=> ROUTE_ON == exp_on)
    else $error("open latch did not pass enable bits");
  a_latch_hold:
    assert property (($past(ce_n) || $past(update_n)) |->
      $stable(ROUTE_SRC) && (!$past(reset_n) || $stable(ROUTE_ON)))
    else $error("matrix changed while latch closed");
  a_xpt_decode:
    assert property (ROUTE_XPT == exp_xpt)
    else $error("crosspoint decode wrong");
  a_reset_off:
    assert property (!reset_n |=> ROUTE_ON == 8'h00)
    else $error("reset did not disable outputs");
  a_upd_high_clk:
    assert property (take |-> update_n)
    else $error("clock fell with update low");
  a_pad_zeros:
    assert property (t_ser && pos_ff < 7'h28 |-> !data_in)
    else $error("leading pad bit not zero");
  a_ce_clk_high:
    assert property ($fell(ce_n) |-> prog_clk)
    else $error("clock low when device selected");
endmodule
`default_nettype wire

// ---- testbench/tb_crosspoint_program_loader.sv ----
// self-checking bench: host end programs the device end across the pins
`timescale 1ns/10ps
`default_nettype none
`include "cpl_defs.svh"
module tb_crosspoint_program_loader;
  import cpl_pkg::*;
  logic            clk_sys = 1'b0;
  logic            srst = 1'b1;
  logic            cmd_valid = 1'b0;
  logic            cmd_serial = 1'b0;
  logic            cmd_commit = 1'b0;
  logic [2:0]      cmd_addr = 3'h0;
  logic [3:0]      cmd_src = 4'h0;
  logic            cmd_on = 1'b0;
  logic            reset_req = 1'b0;
  cpl_srcs_t [0:0] map_src = '0;
  cpl_ons_t  [0:0] map_on = '0;
  logic            cmd_ready;
  logic            cmd_done;
  cpl_srcs_t       route_src;
  cpl_ons_t        route_on;
  logic [127:0]    route_xpt;
  logic [39:0]     exp_q[$];
  // load rank and matrix as they should stand
  cpl_srcs_t       sh_src = '0;
  cpl_ons_t        sh_on = '0;
  logic [39:0]     route_mdl = '0;
  int              num_errors = 0;
  int              checked = 0;

  cpl_prog_if pins ();
  cpl_device cpl_device_inst (.CLK_SYS(clk_sys), .SRST(srst),
    .PINS(pins.dev), .ROUTE_SRC(route_src), .ROUTE_ON(route_on),
    .ROUTE_XPT(route_xpt));
  cpl_host #(.CHAIN_LEN(1), .HALF_CYC(2), .CNT_W(8)) cpl_host_inst (
    .CLK_SYS(clk_sys), .SRST(srst), .PINS(pins.host),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_SERIAL(cmd_serial),
    .CMD_COMMIT(cmd_commit), .CMD_ADDR(cmd_addr), .CMD_SRC(cmd_src),
    .CMD_ON(cmd_on), .MAP_SRC(map_src), .MAP_ON(map_on),
    .CMD_DONE(cmd_done), .RESET_REQ(reset_req));
  cpl_monitor cpl_monitor_inst (.CLK_SYS(clk_sys), .SRST(srst),
    .ce_n(pins.ce_n), .prog_clk(pins.prog_clk), .data_in(pins.data_in),
    .data_out(pins.data_out), .update_n(pins.update_n),
    .load_mode_select(pins.load_mode_select),
    .output_select_lines(pins.output_select_lines),
    .source_select_bits(pins.source_select_bits),
    .output_on_bit(pins.output_on_bit), .reset_n(pins.reset_n),
    .ROUTE_SRC(route_src), .ROUTE_ON(route_on), .ROUTE_XPT(route_xpt));

  always #2 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t ns route %h expected %h", $time, got, exp);
    end
  endtask

  // called at a falling edge with the host idle
  task automatic cmd(input logic ser, input logic com, input logic [2:0] a,
                     input logic [3:0] s, input logic o);
    cmd_serial = ser;
    cmd_commit = com;
    cmd_addr = a;
    cmd_src = s;
    cmd_on = o;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1)
      @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic ser();
    map_src[0] = cpl_srcs_t'($urandom);
    map_on[0] = cpl_ons_t'($urandom);
    sh_src = map_src[0];
    sh_on = map_on[0];
    route_mdl = {sh_src, sh_on};
    exp_q.push_back(route_mdl);
    cmd(1'b1, 1'b1, 3'h0, 4'h0, 1'b0);
  endtask

  task automatic par(input logic [2:0] a, input logic com);
    logic [3:0] s;
    logic       o;
    s = 4'($urandom);
    o = 1'($urandom);
    sh_src[a*4 +: 4] = s;
    sh_on[a] = o;
    if (com)
      route_mdl = {sh_src, sh_on};
    exp_q.push_back(route_mdl);
    cmd(1'b0, com, a, s, o);
  endtask

  always @(negedge clk_sys)
    if (cmd_done === 1'b1 && exp_q.size() > 0)
      chk({route_src, route_on}, exp_q.pop_front());

  initial
  begin
    void'($urandom(15));
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    // second pass pushes the first word out of the far end
    ser();
    ser();
    // all entries written with update high, one update at the end
    for (int a = 0; a < 8; a++)
      par(3'(a), a == 7);
    repeat (3) par(3'($urandom), 1'b1);
    reset_req = 1'b1;
    repeat (4) @(negedge clk_sys);
    route_mdl[7:0] = 8'h00;
    chk({route_src, route_on}, route_mdl);
    reset_req = 1'b0;
    @(negedge clk_sys);
    // enables kept in the load rank come back with the next update
    par(3'($urandom), 1'b1);
    ser();
    conclude();
  end

  initial
  begin
    #40000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
